// ===== rfs_supervisor.sv
// fault supervision and protection sequencing for a dual ldo with boost
`timescale 1ns/1ps
`default_nettype none
`include "rfs_cfg.svh"
module rfs_supervisor #(
    parameter int RETRY_US  = `RFS_RETRY_MS * `RFS_US_PER_MS,
    parameter int SS_US     = `RFS_SS_MS * `RFS_US_PER_MS,
    parameter int US_PER_MS = `RFS_US_PER_MS,
    parameter int TICK_CYC  = `RFS_TICK_CYC
) (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_b_i,
    input  wire logic               en_pin_i,
    input  wire logic               vin_ok_i,
    input  wire logic               vcc_ok_i,
    input  wire logic               thermal_i,
    input  wire logic [1:0]         short_to_battery_i,
    input  wire rfs_pkg::rfs_warn_t warn_i,
    input  wire logic               dev_en_sw_i,
    input  wire logic               boost_en_sw_i,
    input  wire logic               ldo1_en_sw_i,
    input  wire logic               ldo2_en_sw_i,
    input  wire logic               fault_mode_i,
    input  wire logic [1:0]         blank_sel_i,
    input  wire logic               dither_en_i,
    input  wire logic               tracking_en_i,
    output logic                    fault_out_n_o,
    output logic                    fault_out_n_oe_o,
    output rfs_pkg::rfs_status_t    status_o,
    output logic                    boost_on_o,
    output logic                    boost_steady_o,
    output logic                    ldo1_on_o,
    output logic                    ldo2_on_o,
    output logic [1:0]              ldo_ilim_o,
    output logic                    blank_o,
    output logic                    otp_reload_o,
    output logic                    vin_thr_boost_o,
    output logic signed [4:0]       dither_pct_o
);
    localparam int TW = `RFS_TMR_W;
    localparam int SYNC_W = 6 + $bits(rfs_pkg::rfs_warn_t);
    localparam int DITH_CYC = `RFS_DITHER_CYC;

    logic [SYNC_W-1:0]   sync_q;
    logic                en_s;
    logic                vin_s;
    logic                vcc_s;
    logic                therm_s;
    logic [1:0]          stb_s;
    rfs_pkg::rfs_warn_t  warn_s;
    rfs_pkg::rfs_state_t st;
    rfs_pkg::rfs_state_t next_st;
    logic [TW-1:0]       tmr;
    logic [TW-1:0]       blank_len;
    logic [7:0]          div;
    logic                tick;
    logic                vcc_d;
    logic                go;
    logic                prot_fault;
    logic                done_blank;
    logic                done_ss;
    logic                done_retry;
    logic                clr_hit;
    logic                fault_any;
    logic [8:0]          dith_div;
    logic                dith_up;
    rfs_pkg::rfs_warn_t  warn_eff;

    rfs_sync3 #(.W(SYNC_W)) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .d_i       ({en_pin_i, vin_ok_i, vcc_ok_i, thermal_i,
                     short_to_battery_i, warn_i}),
        .q_o       (sync_q)
    );

    assign {en_s, vin_s, vcc_s, therm_s, stb_s, warn_s} = sync_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div  <= 8'h00;
            tick <= 1'b0;
        end else if (div == 8'(TICK_CYC - 1)) begin
            div  <= 8'h00;
            tick <= 1'b1;
        end else begin
            div  <= div + 8'h01;
            tick <= 1'b0;
        end
    end

    always_comb begin
        case (blank_sel_i)
            2'h0:    blank_len = TW'(`RFS_BLANK_MS0 * US_PER_MS);
            2'h1:    blank_len = TW'(`RFS_BLANK_MS1 * US_PER_MS);
            2'h2:    blank_len = TW'(`RFS_BLANK_MS2 * US_PER_MS);
            default: blank_len = TW'(`RFS_BLANK_MS3 * US_PER_MS);
        endcase
    end

    assign go = en_s && vin_s && vcc_s && dev_en_sw_i;
    assign prot_fault = therm_s || (st == rfs_pkg::ST_BLANK && |stb_s);
    assign done_blank = tick && tmr >= blank_len - TW'(1);
    assign done_ss    = tick && tmr >= TW'(SS_US - 1);
    assign done_retry = tick && tmr >= TW'(RETRY_US - 1);
    assign clr_hit    = tick && tmr == TW'(`RFS_CLR_US - 1);

    always_comb begin
        next_st = st;
        case (st)
            rfs_pkg::ST_OFF: begin
                if (go) next_st = rfs_pkg::ST_BLANK;
            end
            rfs_pkg::ST_BLANK, rfs_pkg::ST_SS, rfs_pkg::ST_RUN: begin
                if (prot_fault) begin
                    next_st = fault_mode_i ? rfs_pkg::ST_RETRY
                                           : rfs_pkg::ST_LATCH;
                end else if (st == rfs_pkg::ST_BLANK && done_blank) begin
                    next_st = rfs_pkg::ST_SS;
                end else if (st == rfs_pkg::ST_SS && done_ss) begin
                    next_st = rfs_pkg::ST_RUN;
                end
            end
            rfs_pkg::ST_RETRY: begin
                if (done_retry) next_st = rfs_pkg::ST_BLANK;
            end
            rfs_pkg::ST_LATCH: begin
                // held until supply or enable drops
                next_st = rfs_pkg::ST_LATCH;
            end
            default: next_st = rfs_pkg::ST_OFF;
        endcase
        if (!go) next_st = rfs_pkg::ST_OFF;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= rfs_pkg::ST_OFF;
        end else begin
            st <= next_st;
        end
    end

    // timer restarts on every state entry
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tmr <= '0;
        end else if (next_st != st) begin
            tmr <= '0;
        end else if (tick && tmr != '1) begin
            tmr <= tmr + TW'(1);
        end
    end

    always_comb begin
        warn_eff = warn_s;
        if (tracking_en_i) begin
            warn_eff.ldo_ov = 2'h0;
            warn_eff.ldo_uv = 2'h0;
        end
    end

    // sticky protection flags; a new event beats the clear
    // one process owns the whole status word, so no field has two writers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_o <= '0;
        end else begin
            status_o.warn <= warn_eff;
            if (!vcc_s || (st == rfs_pkg::ST_RUN && clr_hit)) begin
                status_o.thermal <= 1'b0;
                status_o.stb     <= 2'h0;
            end
            if (therm_s && st != rfs_pkg::ST_OFF) begin
                status_o.thermal <= 1'b1;
            end
            if (st == rfs_pkg::ST_BLANK) begin
                // vcc loss drops old bits, a fresh short still lands
                status_o.stb <= (vcc_s ? status_o.stb : 2'h0) | stb_s;
            end
        end
    end

    assign fault_any = |status_o;

    // open drain, driven only to pull low
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fault_out_n_o    <= 1'b0;
            fault_out_n_oe_o <= 1'b0;
        end else begin
            fault_out_n_o    <= 1'b0;
            fault_out_n_oe_o <= fault_any && !tracking_en_i;
        end
    end

    // switch enables only in normal states
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            boost_on_o     <= 1'b0;
            boost_steady_o <= 1'b0;
            ldo1_on_o      <= 1'b0;
            ldo2_on_o      <= 1'b0;
            blank_o        <= 1'b0;
        end else begin
            boost_on_o     <= boost_en_sw_i && (next_st == rfs_pkg::ST_SS ||
                                                next_st == rfs_pkg::ST_RUN);
            boost_steady_o <= boost_en_sw_i && next_st == rfs_pkg::ST_RUN;
            ldo1_on_o      <= ldo1_en_sw_i && next_st == rfs_pkg::ST_RUN;
            ldo2_on_o      <= ldo2_en_sw_i && next_st == rfs_pkg::ST_RUN;
            // window on each start and recovery
            blank_o        <= next_st == rfs_pkg::ST_BLANK;
        end
    end

    // clamp request; output itself stays enabled
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ldo_ilim_o <= 2'h0;
        end else begin
            ldo_ilim_o <= warn_s.ldo_oc;
        end
    end

    // reload pulse on control supply loss
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vcc_d        <= 1'b0;
            otp_reload_o <= 1'b0;
        end else begin
            vcc_d        <= vcc_s;
            otp_reload_o <= vcc_d && !vcc_s;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vin_thr_boost_o <= 1'b0;
        end else begin
            vin_thr_boost_o <= boost_en_sw_i;
        end
    end

    // triangle in whole percent; 4*pct steps make one 9kHz cycle
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dith_div     <= 9'h000;
            dith_up      <= 1'b1;
            dither_pct_o <= 5'sh00;
        end else if (!dither_en_i || !boost_on_o) begin
            dith_div     <= 9'h000;
            dith_up      <= 1'b1;
            dither_pct_o <= 5'sh00;
        end else if (dith_div == 9'(DITH_CYC - 1)) begin
            dith_div <= 9'h000;
            if (dith_up) begin
                dither_pct_o <= dither_pct_o + 5'sh01;
                if (dither_pct_o == 5'(`RFS_DITHER_PCT - 1)) dith_up <= 1'b0;
            end else begin
                dither_pct_o <= dither_pct_o - 5'sh01;
                if (dither_pct_o == 5'(1 - `RFS_DITHER_PCT)) dith_up <= 1'b1;
            end
        end else begin
            dith_div <= dith_div + 9'h001;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_fault_seen;
        fault_any && !tracking_en_i;
    endsequence

    property p_pin_low;
        s_fault_seen |=> fault_out_n_oe_o && !fault_out_n_o;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("fault pin not pulled low on fault");

    property p_track_high;
        tracking_en_i |=> !fault_out_n_oe_o;
    endproperty
    a_track_high: assert property (p_track_high)
        else $error("fault pin driven in tracking mode");

    property p_stb_window;
        $rose(|status_o.stb) |-> $past(st == rfs_pkg::ST_BLANK);
    endproperty
    a_stb_window: assert property (p_stb_window)
        else $error("stb flagged outside blank window");

    property p_en_prio;
        !en_s |=> st == rfs_pkg::ST_OFF ##1 !ldo1_on_o && !boost_on_o;
    endproperty
    a_en_prio: assert property (p_en_prio)
        else $error("enable pin low did not switch off");

    property p_latch_hold;
        st == rfs_pkg::ST_LATCH && go |=> st == rfs_pkg::ST_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch-off left without supply or enable cycle");

    sequence s_therm_run;
        st == rfs_pkg::ST_RUN && therm_s && go;
    endsequence

    property p_therm_off;
        s_therm_run |=> !ldo1_on_o && !ldo2_on_o &&
                        (st == (fault_mode_i ? rfs_pkg::ST_RETRY
                                             : rfs_pkg::ST_LATCH));
    endproperty
    a_therm_off: assert property (p_therm_off)
        else $error("thermal fault did not stop ldos");

    property p_retry_blank;
        st == rfs_pkg::ST_RETRY && done_retry && go
            |=> st == rfs_pkg::ST_BLANK && blank_o;
    endproperty
    a_retry_blank: assert property (p_retry_blank)
        else $error("retry did not reopen blank window");

    property p_ilim;
        warn_s.ldo_oc[0] && ldo1_on_o && ldo1_en_sw_i && go && !therm_s
            |=> ldo_ilim_o[0] && ldo1_on_o;
    endproperty
    a_ilim: assert property (p_ilim)
        else $error("current limit dropped ldo or missed clamp");

    property p_otp;
        $fell(vcc_s) |=> otp_reload_o ##1 !otp_reload_o;
    endproperty
    a_otp: assert property (p_otp)
        else $error("no single reload pulse on vcc loss");

    property p_ss_run;
        st == rfs_pkg::ST_SS |-> !ldo1_on_o && !boost_steady_o;
    endproperty
    a_ss_run: assert property (p_ss_run)
        else $error("steady or ldo on during soft start");
endmodule
`default_nettype wire

// ===== rfs_cfg.svh
// timing constants and field codes for the regulator fault supervisor
// How it works
// - fault pin released normally, pulled low on any fault or warning
// - every fault type owns a status flag
// - fault-mode input picks latch-off (0) or hiccup (1) for thermal and stb
// - ldo oc/ov/uv/open-load and boost oc/ov/uv flag and pull the pin; ldo oc also clamps
// - hiccup: after shutdown wait 100ms, then retry soft start
// - hiccup retry repeats without limit while the fault stays
// - hiccup flags clear after 80us of uninterrupted normal run
// - latch-off holds converter stopped until supply or enable cycles
// - after latch release, restart only after the blank interval
// - ldo at current limit is clamped, flagged, pin pulled, stays on
// - persisting over-current into thermal shutdown disables both ldos
// - blank window opens on enable and on every recovery
// - stb tested only in blank window, before switches turn on
// - stb arising outside blank window is not detected
// - stb fault stops all switches per mode, pulls pin, flags channel
// - blank window 1ms to 15ms by two-bit select, default 15ms
// - control supply lockout shuts down and reloads otp settings
// - input lockout threshold depends on boost enable; dip forces full start
// - separate software enables for boost, ldo1 and ldo2
// - enable pin low turns all off whatever software enables say
// - boost dither +-10% with 9kHz cycle, on after reset
// - boost soft start lasts 1ms before steady state
// - tracking mode keeps pin high, ldo ov/uv invalid
`ifndef RFS_CFG_SVH
`define RFS_CFG_SVH

`define RFS_CLK_NS      10
`define RFS_TICK_NS     1000
`define RFS_TICK_CYC    (`RFS_TICK_NS / `RFS_CLK_NS)
`define RFS_US_PER_MS   1000
`define RFS_RETRY_MS    100
`define RFS_CLR_US      80
`define RFS_SS_MS       1
`define RFS_BLANK_MS0   1
`define RFS_BLANK_MS1   5
`define RFS_BLANK_MS2   10
`define RFS_BLANK_MS3   15
`define RFS_BLANK_RST   2'h3
`define RFS_DITHER_HZ   9000
`define RFS_DITHER_PCT  10
`define RFS_DITHER_CYC  (1000000000 / `RFS_CLK_NS / \
                         (`RFS_DITHER_HZ * 4 * `RFS_DITHER_PCT))
`define RFS_TMR_W       17

`endif

// ===== rfs_pkg.sv
// types shared by the regulator fault supervisor
package rfs_pkg;

    typedef struct packed {
        logic [1:0] ldo_oc;
        logic [1:0] ldo_ov;
        logic [1:0] ldo_uv;
        logic [1:0] ldo_ol;
        logic       bst_oc;
        logic       bst_ov;
        logic       bst_uv;
    } rfs_warn_t;

    typedef struct packed {
        logic       thermal;
        logic [1:0] stb;
        rfs_warn_t  warn;
    } rfs_status_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_BLANK,
        ST_SS,
        ST_RUN,
        ST_RETRY,
        ST_LATCH
    } rfs_state_t;

endpackage

// ===== rfs_sync3.sv
// three-stage synchroniser; output moves when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module rfs_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // per bit: take a new level only once two stages agree
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_o <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    q_o[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== rfs_host_model.sv
// host controller model: watches the fault pin and flags, drops channels
`timescale 1ns/1ps
`default_nettype none
module rfs_host_model (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 fault_pin_i,
    input  wire rfs_pkg::rfs_status_t status_i,
    input  wire logic                 police_i,
    input  wire logic [1:0]           want_i,
    output logic                      ldo1_en_o,
    output logic                      ldo2_en_o
);
    logic [1:0] dropped;
    // drop faulty channel
    // a dropped channel stays off until policing is withdrawn
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dropped <= 2'h0;
        end else if (!police_i) begin
            dropped <= 2'h0;
        end else if (!fault_pin_i) begin
            dropped <= dropped | status_i.warn.ldo_oc;
        end
    end
    assign ldo1_en_o = want_i[0] & ~dropped[0];
    assign ldo2_en_o = want_i[1] & ~dropped[1];
endmodule
`default_nettype wire

// ===== rfs_supervisor_tb.sv
// self-checking bench for the regulator fault supervisor
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor_tb;
    localparam int TK = 2;
    localparam int UPM = 10;
    localparam int RT = 50;
    localparam int SS = 20;
    logic clk_sys = 1'b0, rst_b = 1'b0, en = 1'b0, vin = 1'b1, vcc = 1'b1;
    logic thermal = 1'b0, dev_en = 1'b1, boost_en = 1'b1, mode = 1'b1;
    logic dith = 1'b1, trk = 1'b0, police = 1'b0;
    logic [1:0] stb = 2'h0, bsel = 2'h3, want = 2'h3, ilim;
    rfs_pkg::rfs_warn_t   warn = '0;
    rfs_pkg::rfs_status_t st;
    logic fo_n, oe, b_on, b_st, l1, l2, blank, otp, thr, l1en, l2en, pin;
    logic signed [4:0] dpct;
    int error_cnt = 0, n_tests = 0;
    logic [31:0] seed = 32'h00009f4e;

    always #5 clk_sys = ~clk_sys;
    // pull-up on the fault line; released means high
    assign pin = oe ? fo_n : 1'b1;

    rfs_supervisor #(.RETRY_US(RT), .SS_US(SS), .US_PER_MS(UPM),
                     .TICK_CYC(TK)) dut (
        .clk_sys_i(clk_sys), .rst_b_i(rst_b), .en_pin_i(en),
        .vin_ok_i(vin), .vcc_ok_i(vcc), .thermal_i(thermal),
        .short_to_battery_i(stb), .warn_i(warn), .dev_en_sw_i(dev_en),
        .boost_en_sw_i(boost_en), .ldo1_en_sw_i(l1en),
        .ldo2_en_sw_i(l2en), .fault_mode_i(mode), .blank_sel_i(bsel),
        .dither_en_i(dith), .tracking_en_i(trk), .fault_out_n_o(fo_n),
        .fault_out_n_oe_o(oe), .status_o(st), .boost_on_o(b_on),
        .boost_steady_o(b_st), .ldo1_on_o(l1), .ldo2_on_o(l2),
        .ldo_ilim_o(ilim), .blank_o(blank), .otp_reload_o(otp),
        .vin_thr_boost_o(thr), .dither_pct_o(dpct));

    rfs_host_model host (
        .clk_sys_i(clk_sys), .rst_b_i(rst_b), .fault_pin_i(pin),
        .status_i(st), .police_i(police), .want_i(want),
        .ldo1_en_o(l1en), .ldo2_en_o(l2en));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int blank_ms(input logic [1:0] s);
        case (s)
            2'h0: return 1;
            2'h1: return 5;
            2'h2: return 10;
            default: return 15;
        endcase
    endfunction

    // tracking hides ldo over- and under-voltage
    function automatic rfs_pkg::rfs_warn_t exp_warn(
        input rfs_pkg::rfs_warn_t w, input logic t);
        exp_warn = w;
        if (t) begin
            exp_warn.ldo_ov = 2'h0;
            exp_warn.ldo_uv = 2'h0;
        end
    endfunction

    function automatic logic sig(input int s);
        case (s)
            0: return blank;
            1: return b_st;
            2: return l1;
            3: return oe;
            default: return st.stb[1];
        endcase
    endfunction

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // durations are quantised to the TK-cycle tick plus synchroniser lag
    task automatic chk_near(input int got, input int exp);
        n_tests++;
        if (got < exp - TK - 3 || got > exp + TK + 3) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_for(input int s, input logic v, input int lim,
                            output int n);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            step(1);
            n++;
        end
        chk(16'(n < lim), 16'h0001);
    endtask

    task automatic start_up(input logic [1:0] sel);
        int n;
        bsel = sel;
        en = 1'b1;
        wait_for(0, 1'b1, 20, n);
        wait_for(0, 1'b0, 400, n);
        chk_near(n, blank_ms(sel) * UPM * TK);
        chk({b_on, b_st}, 16'h0002);
        wait_for(1, 1'b1, 100, n);
        chk_near(n, SS * TK);
        chk({l1, l2}, {want[0], want[1]});
    endtask

    initial begin
        int n, mx, mn;
        logic [31:0] r;
        rfs_pkg::rfs_warn_t w;
        step(3);
        rst_b = 1'b1;
        chk({pin, oe, b_on, l1, l2, blank, otp}, 16'h0040);
        for (int c = 0; c < 4; c++) begin
            start_up(c[1:0]);
            en = 1'b0;
            step(8);
            chk({b_on, l1, l2}, 16'h0000);
        end
        start_up(2'h0);
        chk(thr, boost_en);
        boost_en = 1'b0;
        step(2);
        chk({thr, b_on, b_st, l1}, 16'h0001);
        boost_en = 1'b1;
        step(2);
        chk({thr, b_on, b_st, l1}, 16'h000f);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            w = (i == 0) ? '0 : rfs_pkg::rfs_warn_t'(r[10:0]);
            trk = (i == 1) ? 1'b1 : r[11];
            warn = w;
            step(8);
            chk(st.warn, exp_warn(w, trk));
            chk(pin, trk || w == '0);
            chk({l1, l2, b_on}, 16'h0007);
            chk(ilim, w.ldo_oc);
        end
        trk = 1'b0;
        warn = '0;
        warn.ldo_oc = 2'h2;
        // let the last random flags drain before the host starts policing
        step(8);
        police = 1'b1;
        step(12);
        chk({l1, l2}, 16'h0002);
        police = 1'b0;
        warn = '0;
        step(8);
        stb = 2'h1;
        step(20);
        chk({st.stb, l1}, 16'h0001);
        stb = 2'h0;
        mx = -99;
        mn = 99;
        repeat (12000) begin
            step(1);
            mx = (int'(dpct) > mx) ? int'(dpct) : mx;
            mn = (int'(dpct) < mn) ? int'(dpct) : mn;
        end
        chk(mx[15:0], 16'h000a);
        chk(mn[15:0], 16'hfff6);
        dith = 1'b0;
        step(8);
        chk(16'(dpct), 16'h0000);
        mode = 1'b0;
        thermal = 1'b1;
        wait_for(3, 1'b1, 12, n);
        chk({st.thermal, l1, l2, b_on}, 16'h0008);
        thermal = 1'b0;
        step(RT * TK * 2);
        chk({l1, l2, b_on, blank, pin}, 16'h0000);
        en = 1'b0;
        step(8);
        start_up(2'h0);
        vcc = 1'b0;
        mode = 1'b1;
        stb = 2'h2;
        n = 0;
        repeat (12) begin
            step(1);
            n += int'(otp);
        end
        chk(n[15:0], 16'h0001);
        chk({st.thermal, l1}, 16'h0000);
        vcc = 1'b1;
        wait_for(4, 1'b1, 40, n);
        step(2);
        chk({l1, l2, b_on, blank, pin}, 16'h0000);
        wait_for(0, 1'b1, RT * TK + 20, n);
        chk_near(n, RT * TK);
        wait_for(0, 1'b0, 40, n);
        chk({b_on, st.stb}, 16'h0002);
        stb = 2'h0;
        wait_for(0, 1'b1, RT * TK + 20, n);
        wait_for(2, 1'b1, 200, n);
        wait_for(4, 1'b0, 400, n);
        chk_near(n, 80 * TK);
        step(2);
        chk(pin, 1'b1);
        end_sim();
    end

    initial begin
        #900000;
        error_cnt++;
        end_sim();
    end
endmodule
`default_nettype wire
